// file: shared/css_pkg.sv
// Purpose: Constants and types for the configuration scheme selector.
// Assumes: System clock of 125 MHz.
// Notes:   Wait and timeout counts are derived from times in their own unit.
`default_nettype none
package css_pkg;
    localparam logic [2:0] CSS_SEL_STREAM32 = 3'h0;
    localparam logic [2:0] CSS_SEL_FLASHFST = 3'h1;
    localparam logic [2:0] CSS_SEL_FLASHNRM = 3'h3;
    localparam logic [2:0] CSS_SEL_CARD     = 3'h4;
    localparam logic [2:0] CSS_SEL_STREAM16 = 3'h5;
    localparam logic [2:0] CSS_SEL_STREAM8  = 3'h6;
    localparam logic [2:0] CSS_SEL_BSCAN    = 3'h7;

    localparam int CSS_CLK_MHZ        = 125;
    localparam int CSS_NORMAL_WAIT_MS = 10;
    localparam int CSS_NORMAL_WAIT_CYC = CSS_NORMAL_WAIT_MS * 1000 * CSS_CLK_MHZ;
    localparam int CSS_RESP_TMO_US    = 2;
    localparam int CSS_RESP_TMO_CYC   = CSS_RESP_TMO_US * CSS_CLK_MHZ;

    localparam int CSS_WIDTH_W32 = 32;
    localparam logic [1:0] CSS_WSEL_X8  = 2'h0;
    localparam logic [1:0] CSS_WSEL_X16 = 2'h1;
    localparam logic [1:0] CSS_WSEL_X32 = 2'h2;

    localparam logic [1:0] CSS_ADDR3 = 2'h3;
    localparam logic [1:0] CSS_ADDR4 = 2'h0;

    typedef enum logic [2:0] {
        CSS_SCH_NONE     = 3'h0,
        CSS_SCH_STREAM   = 3'h1,
        CSS_SCH_FLASH    = 3'h2,
        CSS_SCH_CARD     = 3'h3,
        CSS_SCH_BSCAN    = 3'h4
    } css_scheme_t;

    typedef enum logic [2:0] {
        CSS_ST_IDLE  = 3'h0,
        CSS_ST_WAIT  = 3'h1,
        CSS_ST_PROBE = 3'h2,
        CSS_ST_LOAD  = 3'h3,
        CSS_ST_USER  = 3'h4,
        CSS_ST_FAIL  = 3'h5
    } css_state_t;
endpackage
`default_nettype wire

// file: src/css_sync.sv
// Purpose: Two-stage synchroniser for a bus of pin levels.
// Assumes: Inputs are asynchronous to the clock.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module css_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule
`default_nettype wire

// file: src/css_top.sv
// Purpose: Selects the configuration scheme and sequences the load.
// Assumes: Pins and link clock are asynchronous; stream words settle before the clock edge.
// Notes:   The rules carried by this block are listed below.
`timescale 1ns/1ps
`default_nettype none
module css_top
    import css_pkg::*;
#(
    parameter int NORMAL_WAIT_CYC = css_pkg::CSS_NORMAL_WAIT_CYC
) (
    // Clock and reset
    input  wire logic        SYS_CLK_I,
    input  wire logic        RSTN_I,
    // Scheme select and options
    input  wire logic [2:0]  SCHEME_SELECT_PINS_I,
    input  wire logic        BSCAN_REQ_I,
    input  wire logic        BSCAN_DISABLED_I,
    input  wire logic        FABRIC_FIRST_I,
    input  wire logic        RECONFIG_REQ_I,
    // Parallel stream port
    input  wire logic        CFG_STREAM_CLOCK_I,
    input  wire logic        CFG_STREAM_PRESENT_I,
    input  wire logic [31:0] CFG_STREAM_WORD_I,
    input  wire logic        DECOMP_BUSY_I,
    // Flash and card memory
    input  wire logic        MEM_RESPONDED_I,
    input  wire logic        FW_LOADED_I,
    input  wire logic        LOAD_DONE_I,
    // PCIe link
    input  wire logic        PCIE_TRAINED_I,
    input  wire logic [4:0]  PCIE_LANES_I,
    input  wire logic        PCIE_LOAD_REQ_I,
    // Status and controls
    output logic [2:0]       SCHEME_O,
    output logic [1:0]       STREAM_WIDTH_O,
    output logic             CFG_STREAM_ACCEPT_O,
    output logic [31:0]      STREAM_WORD_O,
    output logic             STREAM_WORD_VALID_O,
    output logic             DEVICE_MASTER_O,
    output logic             MEM_READ_REQ_O,
    output logic [1:0]       FLASH_ADDR_BYTES_O,
    output logic             MEM_MISSING_O,
    output logic             CFG_FAIL_O,
    output logic             USER_MODE_O,
    output logic             WIDE_PINS_RELEASED_O,
    output logic             PCIE_LOAD_EN_O
);
    ////////////////////////////////////////////////////////////////////////////
    logic [2:0]  sel_s;
    logic        bs_req_s, bs_dis_s, ff_s, rcfg_s, sclk_s, pres_s, busy_s;
    logic        resp_s, fw_s, done_s, trn_s, preq_s;
    logic [4:0]  lanes_s;

    css_sync #(.W(20)) u_sync (
        .clk_i   (SYS_CLK_I),
        .rst_n_i (RSTN_I),
        .d_i     ({SCHEME_SELECT_PINS_I, BSCAN_REQ_I, BSCAN_DISABLED_I, FABRIC_FIRST_I,
                   RECONFIG_REQ_I, CFG_STREAM_CLOCK_I, CFG_STREAM_PRESENT_I,
                   DECOMP_BUSY_I, MEM_RESPONDED_I, FW_LOADED_I, LOAD_DONE_I,
                   PCIE_TRAINED_I, PCIE_LANES_I, PCIE_LOAD_REQ_I}),
        .q_o     ({sel_s, bs_req_s, bs_dis_s, ff_s, rcfg_s, sclk_s, pres_s, busy_s,
                   resp_s, fw_s, done_s, trn_s, lanes_s, preq_s})
    );

    // Stream data bits are held stable by the host across the clock edge.
    logic [31:0] word_m_q, word_s_q;
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            word_m_q <= 32'h0;
            word_s_q <= 32'h0;
        end else begin
            word_m_q <= CFG_STREAM_WORD_I;
            word_s_q <= word_m_q;
        end
    end

    function automatic css_scheme_t decode_sel(input logic [2:0] s);
        unique case (s)
            CSS_SEL_STREAM32, CSS_SEL_STREAM16, CSS_SEL_STREAM8: decode_sel = CSS_SCH_STREAM;
            CSS_SEL_FLASHFST, CSS_SEL_FLASHNRM: decode_sel = CSS_SCH_FLASH;
            CSS_SEL_CARD:  decode_sel = CSS_SCH_CARD;
            CSS_SEL_BSCAN: decode_sel = CSS_SCH_BSCAN;
            default:       decode_sel = CSS_SCH_NONE;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Select capture: one pass after reset or on a reconfiguration request.
    logic        cap_pend_q, rcfg_d1_q;
    logic [2:0]  sel_q;
    css_scheme_t sch_q;
    logic        rcfg_rise;
    assign rcfg_rise = rcfg_s && !rcfg_d1_q;

    // Wait three cycles so the synchroniser holds real pin levels first.
    logic [1:0] cap_dly_q;
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cap_pend_q <= 1'b1;
            cap_dly_q  <= 2'h0;
            rcfg_d1_q  <= 1'b0;
            sel_q      <= CSS_SEL_STREAM32;
            sch_q      <= CSS_SCH_NONE;
        end else begin
            rcfg_d1_q <= rcfg_s;
            if (rcfg_rise) begin
                cap_pend_q <= 1'b1;
                cap_dly_q  <= 2'h0;
            end else if (cap_pend_q) begin
                cap_dly_q <= cap_dly_q + 2'h1;
                if (cap_dly_q == 2'h3) begin
                    cap_pend_q <= 1'b0;
                    sel_q      <= sel_s;
                    sch_q      <= decode_sel(sel_s);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    css_state_t st_q;
    logic [31:0] cnt_q;
    logic        bs_act;
    logic        fast_loaded_q;
    assign bs_act = (bs_req_s || sch_q == CSS_SCH_BSCAN) && !bs_dis_s;

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            st_q          <= CSS_ST_IDLE;
            cnt_q         <= 32'h0;
            fast_loaded_q <= 1'b0;
            MEM_MISSING_O <= 1'b0;
            CFG_FAIL_O    <= 1'b0;
        end else if (rcfg_rise || cap_pend_q) begin
            st_q  <= CSS_ST_IDLE;
            cnt_q <= 32'h0;
            if (rcfg_rise) begin
                MEM_MISSING_O <= 1'b0;
                CFG_FAIL_O    <= 1'b0;
            end
        end else begin
            cnt_q <= cnt_q + 32'h1;
            unique case (st_q)
                CSS_ST_IDLE: begin
                    cnt_q <= 32'h0;
                    if (bs_act || sch_q == CSS_SCH_STREAM)
                        st_q <= CSS_ST_LOAD;
                    else if (sel_q == CSS_SEL_FLASHNRM)
                        st_q <= CSS_ST_WAIT;
                    else if (sch_q == CSS_SCH_FLASH || sch_q == CSS_SCH_CARD)
                        st_q <= CSS_ST_PROBE;
                end
                CSS_ST_WAIT: begin
                    if (cnt_q >= 32'(NORMAL_WAIT_CYC - 1)) begin
                        st_q  <= CSS_ST_PROBE;
                        cnt_q <= 32'h0;
                    end
                end
                CSS_ST_PROBE: begin
                    if (resp_s) begin
                        st_q <= CSS_ST_LOAD;
                    end else if (cnt_q >= 32'(CSS_RESP_TMO_CYC - 1)) begin
                        st_q          <= CSS_ST_FAIL;
                        MEM_MISSING_O <= 1'b1;
                        CFG_FAIL_O    <= 1'b1;
                    end
                end
                CSS_ST_LOAD: begin
                    if (done_s) begin
                        st_q <= CSS_ST_USER;
                        if (sel_q == CSS_SEL_FLASHFST && !bs_act)
                            fast_loaded_q <= 1'b1;
                    end
                end
                CSS_ST_USER: cnt_q <= 32'h0;
                CSS_ST_FAIL: cnt_q <= 32'h0;
                default:     st_q  <= CSS_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    logic loading, stream_mode, pcie_ok;
    assign loading     = (st_q == CSS_ST_LOAD);
    assign stream_mode = (sch_q == CSS_SCH_STREAM) && !bs_act;
    assign pcie_ok     = fast_loaded_q && trn_s && ff_s &&
                         (lanes_s == 5'h8 || lanes_s == 5'h10);

    logic sclk_d1_q;
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            sclk_d1_q           <= 1'b0;
            SCHEME_O            <= 3'h0;
            STREAM_WIDTH_O      <= CSS_WSEL_X32;
            CFG_STREAM_ACCEPT_O <= 1'b0;
            STREAM_WORD_O       <= 32'h0;
            STREAM_WORD_VALID_O <= 1'b0;
            DEVICE_MASTER_O     <= 1'b0;
            MEM_READ_REQ_O      <= 1'b0;
            FLASH_ADDR_BYTES_O  <= CSS_ADDR3;
            USER_MODE_O         <= 1'b0;
            WIDE_PINS_RELEASED_O <= 1'b0;
            PCIE_LOAD_EN_O      <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_s;
            SCHEME_O  <= bs_act ? CSS_SCH_BSCAN : sch_q;
            unique case (sel_q)
                CSS_SEL_STREAM16: STREAM_WIDTH_O <= CSS_WSEL_X16;
                CSS_SEL_STREAM8:  STREAM_WIDTH_O <= CSS_WSEL_X8;
                default:          STREAM_WIDTH_O <= CSS_WSEL_X32;
            endcase
            CFG_STREAM_ACCEPT_O <= loading && stream_mode && !busy_s;
            STREAM_WORD_VALID_O <= loading && stream_mode && !busy_s &&
                                   CFG_STREAM_ACCEPT_O && pres_s && sclk_s && !sclk_d1_q;
            if (sel_q == CSS_SEL_STREAM8)
                STREAM_WORD_O <= {24'h0, word_s_q[7:0]};
            else if (sel_q == CSS_SEL_STREAM16)
                STREAM_WORD_O <= {16'h0, word_s_q[15:0]};
            else
                STREAM_WORD_O <= word_s_q;
            DEVICE_MASTER_O <= !bs_act &&
                               (sch_q == CSS_SCH_FLASH || sch_q == CSS_SCH_CARD);
            MEM_READ_REQ_O  <= !bs_act && (st_q == CSS_ST_PROBE || loading) &&
                               (sch_q == CSS_SCH_FLASH || sch_q == CSS_SCH_CARD);
            if (st_q == CSS_ST_IDLE)
                FLASH_ADDR_BYTES_O <= CSS_ADDR3;
            else if (fw_s && sch_q == CSS_SCH_FLASH)
                FLASH_ADDR_BYTES_O <= CSS_ADDR4;
            USER_MODE_O <= (st_q == CSS_ST_USER);
            WIDE_PINS_RELEASED_O <= (st_q == CSS_ST_USER) &&
                                    (sel_q == CSS_SEL_STREAM32 || sel_q == CSS_SEL_STREAM16);
            // Loads over the link need it trained at x8 or x16 after a fast flash load; they run from user mode only.
            PCIE_LOAD_EN_O <= pcie_ok && preq_s && (st_q == CSS_ST_USER);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_ACCEPT_BUSY: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        busy_s |=> !CFG_STREAM_ACCEPT_O) else $error("accept while busy");
    AST_PCIE_GATE: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        PCIE_LOAD_EN_O |-> fast_loaded_q) else $error("pcie load before flash load");
    AST_FABRIC_FIRST: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        !ff_s |=> !PCIE_LOAD_EN_O) else $error("pcie load without fabric first");
    AST_MISSING: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        $rose(MEM_MISSING_O) |-> CFG_FAIL_O && $past(st_q) == CSS_ST_PROBE)
        else $error("missing memory without probe");
    AST_RELEASE: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        WIDE_PINS_RELEASED_O |-> sel_q != CSS_SEL_STREAM8 && USER_MODE_O)
        else $error("bad pin release");
    AST_ADDR4: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        $fell(FLASH_ADDR_BYTES_O[0]) |-> $past(fw_s)) else $error("early four-byte");
    AST_MASTER: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        DEVICE_MASTER_O |-> !CFG_STREAM_ACCEPT_O) else $error("master and slave");
    AST_SEL_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        !cap_pend_q && !rcfg_rise |=> $stable(sel_q)) else $error("select changed");
    AST_BSCAN: assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        bs_req_s && !bs_dis_s |=> SCHEME_O == CSS_SCH_BSCAN) else $error("no override");
endmodule
`default_nettype wire

// file: verification/css_host_model.sv
// Purpose: Stream host and flash responder facing the scheme selector.
// Assumes: The bench calls the tasks just after a system clock edge.
// Notes:   The stream clock stands still outside a word; released data shows its inverse.
`timescale 1ns/1ps
`default_nettype none
module css_host_model (
    // Clock and status from the block
    input  wire logic        clk_i,
    input  wire logic        accept_i,
    input  wire logic        mem_req_i,
    // Stream host side
    output logic             stream_clk_o,
    output logic             present_o,
    output logic [31:0]      word_o,
    // Memory side
    output logic             responded_o,
    output logic             fw_loaded_o,
    output logic             load_done_o
);
    initial begin
        stream_clk_o = 1'b0;
        present_o    = 1'b0;
        word_o       = 32'h0;
        clear();
    end
    task automatic clear();
        responded_o = 1'b0;
        fw_loaded_o = 1'b0;
        load_done_o = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // A word is offered once the block accepts, or after 200 polls of 8 ns; the odd offset
    // keeps the stream clock out of phase with the system clock.
    task automatic send_word(input logic [31:0] w);
        int i;
        for (i = 0; i < 200 && accept_i !== 1'b1; i++) begin
            #8;
        end
        #37 present_o = 1'b1;
        word_o = w;
        #80 stream_clk_o = 1'b1;
        #80 stream_clk_o = 1'b0;
        present_o = 1'b0;
        word_o = ~w;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // After a delay the memory answers a read that the block started, or any read after 400 cycles without a request.
    task automatic run_flash(input int delay);
        int i;
        for (i = 0; i < 400 && mem_req_i !== 1'b1; i++) begin
            @(posedge clk_i);
        end
        repeat (delay) @(posedge clk_i);
        #1 responded_o = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 fw_loaded_o = 1'b1;
        repeat (6) @(posedge clk_i);
        #1 load_done_o = 1'b1;
    endtask
    task automatic finish_load();
        load_done_o = 1'b1;
    endtask
endmodule
`default_nettype wire

// file: verification/css_top_tb.sv
// Purpose: Self-checking bench for the scheme selector.
// Assumes: Shortened flash wait of 20 cycles; link clock of 160 ns.
// Notes:   Each scenario starts from its own reset with the select pins set.
`timescale 1ns/1ps
`default_nettype none
module css_top_tb;
    import css_pkg::*;
    // Per-step patterns, step 0 in the lowest bits.
    localparam logic [19:0] LANES    = {5'h04, 5'h10, 5'h10, 5'h08};
    localparam logic [3:0]  FF_SEQ   = 4'hb;
    localparam logic [3:0]  PCIE_EXP = 4'h3;
    localparam logic [3:0]  BS_REQ   = 4'h5;
    localparam logic [3:0]  BS_DIS   = 4'h4;
    localparam logic [11:0] BS_CODES = {3'h2, 3'h0, 3'h7, 3'h0};
    localparam logic [11:0] BS_EXP   = {CSS_SCH_NONE, CSS_SCH_STREAM, CSS_SCH_BSCAN,
                                        CSS_SCH_BSCAN};
    logic        sys_clk;
    logic        rst_n        = 1'b0;
    logic [2:0]  sel          = 3'h0;
    logic        bscan_req    = 1'b0;
    logic        bscan_dis    = 1'b0;
    logic        fabric_first = 1'b0;
    logic        reconfig     = 1'b0;
    logic        busy         = 1'b0;
    logic        trained      = 1'b0;
    logic [4:0]  lanes        = 5'h0;
    logic        pcie_req     = 1'b0;
    logic        s_clk, present, responded, fw_loaded, load_done;
    logic [31:0] word, out_word, last_word;
    logic [2:0]  scheme;
    logic [1:0]  width, addr_bytes;
    logic        accept, out_valid, master, mem_req, missing, fail, user, released, pcie_en;
    int          fails = 0;
    int          checked = 0;
    int          nwords = 0;

    css_top #(.NORMAL_WAIT_CYC(20)) dut_u (
        .SYS_CLK_I(sys_clk), .RSTN_I(rst_n), .SCHEME_SELECT_PINS_I(sel),
        .BSCAN_REQ_I(bscan_req), .BSCAN_DISABLED_I(bscan_dis),
        .FABRIC_FIRST_I(fabric_first), .RECONFIG_REQ_I(reconfig),
        .CFG_STREAM_CLOCK_I(s_clk), .CFG_STREAM_PRESENT_I(present),
        .CFG_STREAM_WORD_I(word), .DECOMP_BUSY_I(busy), .MEM_RESPONDED_I(responded),
        .FW_LOADED_I(fw_loaded), .LOAD_DONE_I(load_done), .PCIE_TRAINED_I(trained),
        .PCIE_LANES_I(lanes), .PCIE_LOAD_REQ_I(pcie_req), .SCHEME_O(scheme),
        .STREAM_WIDTH_O(width), .CFG_STREAM_ACCEPT_O(accept), .STREAM_WORD_O(out_word),
        .STREAM_WORD_VALID_O(out_valid), .DEVICE_MASTER_O(master),
        .MEM_READ_REQ_O(mem_req), .FLASH_ADDR_BYTES_O(addr_bytes),
        .MEM_MISSING_O(missing), .CFG_FAIL_O(fail), .USER_MODE_O(user),
        .WIDE_PINS_RELEASED_O(released), .PCIE_LOAD_EN_O(pcie_en));

    css_host_model model (
        .clk_i(sys_clk), .accept_i(accept), .mem_req_i(mem_req), .stream_clk_o(s_clk),
        .present_o(present), .word_o(word), .responded_o(responded),
        .fw_loaded_o(fw_loaded), .load_done_o(load_done));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (out_valid === 1'b1) begin
            nwords    <= nwords + 1;
            last_word <= out_word;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic do_reset(input logic [2:0] s);
        rst_n = 1'b0;
        sel   = s;
        model.clear();
        step(6);
        chk("reset width", width, CSS_WSEL_X32);
        chk("reset addr", addr_bytes, CSS_ADDR3);
        rst_n = 1'b1;
        step(6);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_stream(input logic [2:0] s, input logic [1:0] w, input logic [31:0] m);
        int n0;
        do_reset(s);
        chk("scheme", scheme, CSS_SCH_STREAM);
        chk("width", width, w);
        chk("master", master, 1'b0);
        n0 = nwords;
        model.send_word(32'ha5c3_1e77);
        step(6);
        chk("words", nwords - n0, 1);
        chk("word", last_word, 32'ha5c3_1e77 & m);
        chk("accept", accept, 1'b1);
        busy = 1'b1;
        step(4);
        chk("accept busy", accept, 1'b0);
        busy = 1'b0;
        model.finish_load();
        step(8);
        chk("user", user, 1'b1);
        chk("released", released, w != CSS_WSEL_X8);
        $display("test stream %h done", s);
    endtask
    task automatic t_flash(input logic [2:0] s, input logic fast);
        int i;
        do_reset(s);
        chk("scheme", scheme, CSS_SCH_FLASH);
        chk("master", master, 1'b1);
        for (i = 0; i < 60 && mem_req !== 1'b1; i++) step(1);
        chk("read", mem_req, 1'b1);
        chk("slow start", i >= 14, !fast);
        chk("addr3", addr_bytes, CSS_ADDR3);
        model.run_flash(fast ? 2 : 40);
        step(8);
        chk("addr4", addr_bytes, CSS_ADDR4);
        chk("user", user, 1'b1);
        trained  = 1'b1;
        pcie_req = 1'b1;
        for (i = 0; i < 4; i++) begin
            fabric_first = FF_SEQ[i];
            lanes        = LANES[i*5 +: 5];
            step(6);
            chk("pcie", pcie_en, fast & PCIE_EXP[i]);
        end
        trained  = 1'b0;
        pcie_req = 1'b0;
        $display("test flash %h done", s);
    endtask
    task automatic t_missing();
        int i;
        do_reset(CSS_SEL_FLASHFST);
        for (i = 0; i < 300 && missing !== 1'b1; i++) step(1);
        chk("missing", missing, 1'b1);
        chk("fail", fail, 1'b1);
        sel = CSS_SEL_CARD;
        step(4);
        chk("held", scheme, CSS_SCH_FLASH);
        reconfig = 1'b1;
        step(8);
        reconfig = 1'b0;
        chk("fail clr", fail, 1'b0);
        chk("card", scheme, CSS_SCH_CARD);
        chk("master", master, 1'b1);
        for (i = 0; i < 20 && mem_req !== 1'b1; i++) step(1);
        chk("card read", mem_req, 1'b1);
        $display("test missing done");
    endtask
    task automatic t_bscan();
        for (int i = 0; i < 4; i++) begin
            bscan_req = BS_REQ[i];
            bscan_dis = BS_DIS[i];
            do_reset(BS_CODES[i*3 +: 3]);
            chk("bscan", scheme, BS_EXP[i*3 +: 3]);
        end
        bscan_req = 1'b0;
        bscan_dis = 1'b0;
        $display("test bscan done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // The whole run needs about 700 cycles; the limit leaves wide margin.
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
    initial begin
        t_stream(CSS_SEL_STREAM32, CSS_WSEL_X32, 32'hffff_ffff);
        t_stream(CSS_SEL_STREAM16, CSS_WSEL_X16, 32'h0000_ffff);
        t_stream(CSS_SEL_STREAM8, CSS_WSEL_X8, 32'h0000_00ff);
        t_flash(CSS_SEL_FLASHFST, 1'b1);
        t_flash(CSS_SEL_FLASHNRM, 1'b0);
        t_missing();
        t_bscan();
        tally_and_finish();
    end
endmodule
`default_nettype wire
